//--- include/ssh_defines.svh
// constants for the sensor sample and hex led scan block
// assumes a 20 MHz reference clock and an external a/d converter
`ifndef SSH_DEFINES_SVH
`define SSH_DEFINES_SVH

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define SSH_CLK_NS 50
`define SSH_CLK_KHZ 20000
`define SSH_SAMPLE_MS 500
`define SSH_SAMPLE_CYC (`SSH_SAMPLE_MS * `SSH_CLK_KHZ)
`define SSH_SCAN_NS 3276800
`define SSH_SCAN_CYC (`SSH_SCAN_NS / `SSH_CLK_NS)

// --------------------------------------------------------------
// converter and display
// --------------------------------------------------------------
`define SSH_CHANNEL 4'h1
`define SSH_RESULT_W 10
`define SSH_SEG_RESET 8'h00
`define SSH_SEL_RESET 2'h0
`define SSH_SEG_BLANK 8'h00

// --------------------------------------------------------------
// segment patterns, bit 7 first
// --------------------------------------------------------------
`define SSH_SEG_0 8'h3f
`define SSH_SEG_1 8'h06
`define SSH_SEG_2 8'h5b
`define SSH_SEG_3 8'h4f
`define SSH_SEG_4 8'h66
`define SSH_SEG_5 8'h6d
`define SSH_SEG_6 8'h7d
`define SSH_SEG_7 8'h27
`define SSH_SEG_8 8'h7f
`define SSH_SEG_9 8'h6f
`define SSH_SEG_A 8'h77
`define SSH_SEG_B 8'h7c
`define SSH_SEG_C 8'h39
`define SSH_SEG_D 8'h5e
`define SSH_SEG_E 8'h79
`define SSH_SEG_F 8'h71

`endif

//--- include/ssh_pkg.sv
// types for the sensor sample and hex led scan block
// assumes nothing beyond the defines header
package ssh_pkg;

  typedef enum logic [1:0] {
    ssh_conv_idle,
    ssh_conv_run,
    ssh_conv_restart
  } ssh_conv_t;

  typedef logic [7:0] ssh_seg_t;

endpackage

//--- rtl/ssh_top.sv
// sensor sampler with a four digit multiplexed hex led display
// assumes a converter that raises conv_busy while converting and holds
// conv_result once done; digit lines feed an external 2-to-4 decoder
`timescale 1ns/1ps
`include "ssh_defines.svh"

module ssh_top #(
  parameter int unsigned SAMPLE_CYC = `SSH_SAMPLE_CYC,
  parameter int unsigned SCAN_CYC = `SSH_SCAN_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic conv_busy,
  input wire logic [`SSH_RESULT_W-1:0] conv_result,
  output logic conv_start,
  output logic conv_abort,
  output logic [3:0] conv_channel,
  output logic [7:0] seg_bus,
  output logic [1:0] digit_sel
);

  localparam int SW = $clog2(SAMPLE_CYC + 1);
  localparam int CW = $clog2(SCAN_CYC + 1);
  localparam logic [SW-1:0] SAMPLE_LAST = SW'(SAMPLE_CYC - 1);
  localparam logic [CW-1:0] SCAN_LAST = CW'(SCAN_CYC - 1);

  // ------------------------------------------------------------
  // segment encoder
  // ------------------------------------------------------------
  function automatic ssh_pkg::ssh_seg_t seg_of(input logic [3:0] n);
    case (n)
      4'h0: seg_of = `SSH_SEG_0;
      4'h1: seg_of = `SSH_SEG_1;
      4'h2: seg_of = `SSH_SEG_2;
      4'h3: seg_of = `SSH_SEG_3;
      4'h4: seg_of = `SSH_SEG_4;
      4'h5: seg_of = `SSH_SEG_5;
      4'h6: seg_of = `SSH_SEG_6;
      4'h7: seg_of = `SSH_SEG_7;
      4'h8: seg_of = `SSH_SEG_8;
      4'h9: seg_of = `SSH_SEG_9;
      4'ha: seg_of = `SSH_SEG_A;
      4'hb: seg_of = `SSH_SEG_B;
      4'hc: seg_of = `SSH_SEG_C;
      4'hd: seg_of = `SSH_SEG_D;
      4'he: seg_of = `SSH_SEG_E;
      default: seg_of = `SSH_SEG_F;
    endcase
  endfunction

  // ------------------------------------------------------------
  // time bases
  // ------------------------------------------------------------
  logic [SW-1:0] samp_cnt;
  logic [CW-1:0] scan_cnt;
  logic samp_tick;
  logic scan_tick;
  wire samp_wrap = (samp_cnt == SAMPLE_LAST);
  wire scan_wrap = (scan_cnt == SCAN_LAST);

  // both dividers free-run from reset release, no software start
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      samp_cnt <= '0;
      samp_tick <= 1'b0;
    end else begin
      samp_cnt <= samp_wrap ? '0 : samp_cnt + 1'b1;
      samp_tick <= samp_wrap;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scan_cnt <= '0;
      scan_tick <= 1'b0;
    end else begin
      scan_cnt <= scan_wrap ? '0 : scan_cnt + 1'b1;
      scan_tick <= scan_wrap;
    end
  end

  // ------------------------------------------------------------
  // conversion control
  // ------------------------------------------------------------
  ssh_pkg::ssh_conv_t conv_state;
  ssh_pkg::ssh_conv_t next_conv_state;
  logic have_conv;
  logic next_start;
  logic next_abort;
  logic capture;

  // a conversion still running at the tick is overdue: abort it and
  // start afresh one cycle later, keeping the previous display
  always_comb begin
    next_conv_state = conv_state;
    next_start = 1'b0;
    next_abort = 1'b0;
    capture = 1'b0;
    case (conv_state)
      ssh_pkg::ssh_conv_idle, ssh_pkg::ssh_conv_run: begin
        if (samp_tick) begin
          if (conv_busy) begin
            next_abort = 1'b1;
            next_conv_state = ssh_pkg::ssh_conv_restart;
          end else begin
            capture = have_conv;
            next_start = 1'b1;
            next_conv_state = ssh_pkg::ssh_conv_run;
          end
        end
      end
      ssh_pkg::ssh_conv_restart: begin
        next_start = 1'b1;
        next_conv_state = ssh_pkg::ssh_conv_run;
      end
      default: next_conv_state = ssh_pkg::ssh_conv_idle;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      conv_state <= ssh_pkg::ssh_conv_idle;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      have_conv <= 1'b0;
      conv_channel <= `SSH_CHANNEL;
    end else begin
      conv_state <= next_conv_state;
      conv_start <= next_start;
      conv_abort <= next_abort;
      have_conv <= have_conv | (next_conv_state == ssh_pkg::ssh_conv_run);
      conv_channel <= `SSH_CHANNEL;
    end
  end

  // ------------------------------------------------------------
  // display buffer
  // ------------------------------------------------------------
  logic [7:0] pend [4];
  logic pend_valid;
  logic [7:0] disp [4];
  logic [7:0] view [4];
  wire [11:0] hex_val = {2'b00, conv_result};

  // the fourth position is left dark: three hex digits span the range
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_valid <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        pend[i] <= `SSH_SEG_RESET;
      end
    end else if (capture) begin
      pend[0] <= seg_of(hex_val[3:0]);
      pend[1] <= seg_of(hex_val[7:4]);
      pend[2] <= seg_of(hex_val[11:8]);
      pend[3] <= `SSH_SEG_BLANK;
      pend_valid <= 1'b1;
    end else if (scan_tick) begin
      pend_valid <= 1'b0;
    end
  end

  // committed copy only changes on a digit boundary, so no
  // digit ever shows half of an old and half of a new value
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < 4; i++) begin
        disp[i] <= `SSH_SEG_RESET;
      end
    end else if (scan_tick && pend_valid) begin
      disp <= pend;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      view[i] = pend_valid ? pend[i] : disp[i];
    end
  end

  // ------------------------------------------------------------
  // scan outputs
  // ------------------------------------------------------------
  wire [1:0] next_sel = digit_sel + 2'h1;
  wire [7:0] next_seg = view[next_sel];

  // select and segment data load on the same edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      digit_sel <= `SSH_SEL_RESET;
      seg_bus <= `SSH_SEG_RESET;
    end else if (scan_tick) begin
      digit_sel <= next_sel;
      seg_bus <= next_seg;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_tick_idle;
    samp_tick && !conv_busy;
  endsequence

  sequence s_abort_restart;
    conv_abort && !conv_start ##1 conv_start && !conv_abort;
  endsequence

  a_start_on_tick: assert property (
    s_tick_idle |=> conv_start && !conv_abort)
    else $error("no conversion start after idle tick");

  a_abort_restart: assert property (
    samp_tick && conv_busy |=> s_abort_restart)
    else $error("overdue conversion not aborted and restarted");

  a_start_needs_tick: assert property (
    conv_start |-> $past(samp_tick) || $past(conv_abort))
    else $error("conversion started without a tick");

  a_channel_one: assert property (
    conv_channel == `SSH_CHANNEL)
    else $error("wrong converter channel");

  a_capture_value: assert property (
    s_tick_idle ##0 have_conv |=>
      pend[0] == seg_of($past(conv_result[3:0])) &&
      pend[1] == seg_of($past(conv_result[7:4])) &&
      pend[2] == seg_of({2'b00, $past(conv_result[9:8])}))
    else $error("buffer does not hold the converted value");

  a_one_digit: assert property (
    !scan_tick |=> $stable(digit_sel))
    else $error("digit select moved between scan ticks");

  a_scan_order: assert property (
    scan_tick |=> digit_sel == 2'($past(digit_sel) + 2'h1))
    else $error("scan order broken");

  a_bus_with_sel: assert property (
    !$stable(seg_bus) |-> !$stable(digit_sel))
    else $error("segment bus changed without select");

  a_zero_pattern: assert property (
    capture && conv_result[3:0] == 4'h0 |=> pend[0] == 8'h3f)
    else $error("digit zero pattern wrong");

  a_reset_state: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    srst |=> digit_sel == 2'h0 && seg_bus == 8'h00 && disp[0] == 8'h00)
    else $error("reset state wrong");

  // pulse widths and buffer hold-offs; the scan period itself is
  // checked from the bench, where the shortened counts are known
  a_start_pulse: assert property (
    conv_start |=> !conv_start)
    else $error("conversion start wider than one cycle");

  a_tick_single: assert property (
    samp_tick |=> !samp_tick)
    else $error("sample tick wider than one cycle");

  a_abort_cause: assert property (
    conv_abort |-> $past(samp_tick) && $past(conv_busy))
    else $error("abort without a busy converter at the tick");

  a_busy_keeps: assert property (
    samp_tick && conv_busy |=> $stable(pend[0]) && $stable(pend[1]) && $stable(pend[2]))
    else $error("display buffer loaded from a running conversion");

  a_fourth_dark: assert property (
    digit_sel == 2'h3 |-> seg_bus == 8'h00)
    else $error("fourth digit position not dark");

  a_swap_at_step: assert property (
    !scan_tick |=> $stable(disp[0]) && $stable(disp[1]) && $stable(disp[2]))
    else $error("display copy changed between digit steps");

  a_letter_pattern: assert property (
    capture && conv_result[7:4] == 4'ha |=> pend[1] == 8'h77)
    else $error("letter a pattern wrong");

  a_first_skip: assert property (
    samp_tick && !have_conv |=> $stable(pend[0]) && !pend_valid)
    else $error("result taken before any conversion ran");

endmodule // ssh_top

//--- testbench/ssh_conv_model.sv
// far-side models: the converter behind the start and abort pulses, and
// the decoder-gated lamp drivers behind the shared segment bus
// assumes one-cycle start and abort pulses on ref_clk
`timescale 1ns/1ps
module ssh_conv_model (
  input wire logic ref_clk,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic [3:0] conv_channel,
  input wire logic [9:0] value,
  input wire logic [15:0] conv_len,
  output logic conv_busy,
  output logic [9:0] conv_result
);
  logic [15:0] left;
  initial begin
    conv_busy = 1'b0;
    conv_result = 10'h000;
    left = 16'h0000;
  end
  always @(posedge ref_clk) begin
    if (conv_abort) begin
      conv_busy <= 1'b0;
      left <= 16'h0000;
    end else if (conv_start && conv_channel === 4'h1) begin
      conv_busy <= 1'b1;
      left <= conv_len;
    end else if (left > 16'h0001) begin
      left <= left - 16'h0001;
      // result lines toggle while converting so a stale read is caught
      conv_result <= ~conv_result;
    end else if (conv_busy) begin
      conv_busy <= 1'b0;
      left <= 16'h0000;
      conv_result <= value;
    end
  end
endmodule // ssh_conv_model

// a 2-to-4 decoder enables one non-inverting driver, so only the selected
// digit takes the shared segment bus; lit keeps what each digit showed
module ssh_led_model (
  input wire logic ref_clk,
  input wire logic [1:0] digit_sel,
  input wire logic [7:0] seg_bus,
  output logic [31:0] lit
);
  logic [3:0] digit_en;
  assign digit_en = 4'h1 << digit_sel;
  always @(posedge ref_clk) begin
    for (int p = 0; p < 4; p++) begin
      if (digit_en[p]) begin
        lit[8 * p +: 8] <= seg_bus;
      end
    end
  end
endmodule // ssh_led_model

//--- testbench/testbench.sv
// self-checking bench for the sensor sampler and hex led scan
// assumes the converter model beside it and shortened tick counts
`timescale 1ns/1ps
`include "ssh_defines.svh"
module testbench;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [9:0] value = 10'h000;
  logic [15:0] conv_len = 16'h0005;
  logic conv_busy, conv_start, conv_abort;
  logic [9:0] conv_result;
  logic [3:0] conv_channel;
  logic [7:0] seg_bus;
  logic [1:0] digit_sel;
  int failures = 0;
  int num_checks = 0;
  logic [31:0] lit;
  // each row: converted value, then the patterns of positions 2, 1 and 0;
  // together the rows light every hex pattern somewhere
  logic [33:0] rows [8] = '{
    {10'h000, 8'h3f, 8'h3f, 8'h3f},
    {10'h3ff, 8'h4f, 8'h71, 8'h71},
    {10'h159, 8'h06, 8'h6d, 8'h6f},
    {10'h2ae, 8'h5b, 8'h77, 8'h79},
    {10'h0c7, 8'h3f, 8'h39, 8'h27},
    {10'h3d8, 8'h4f, 8'h5e, 8'h7f},
    {10'h364, 8'h4f, 8'h7d, 8'h66},
    {10'h1b3, 8'h06, 8'h7c, 8'h4f}
  };

  initial forever #25 ref_clk = ~ref_clk;

  ssh_top #(.SAMPLE_CYC(200), .SCAN_CYC(16)) u_dut (
    .ref_clk(ref_clk),
    .srst(srst),
    .conv_busy(conv_busy),
    .conv_result(conv_result),
    .conv_start(conv_start),
    .conv_abort(conv_abort),
    .conv_channel(conv_channel),
    .seg_bus(seg_bus),
    .digit_sel(digit_sel)
  );

  ssh_conv_model u_conv (
    .ref_clk(ref_clk),
    .conv_start(conv_start),
    .conv_abort(conv_abort),
    .conv_channel(conv_channel),
    .value(value),
    .conv_len(conv_len),
    .conv_busy(conv_busy),
    .conv_result(conv_result)
  );

  ssh_led_model u_led (
    .ref_clk(ref_clk),
    .digit_sel(digit_sel),
    .seg_bus(seg_bus),
    .lit(lit)
  );

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // waits on a start pulse, or on an abort pulse when abort is set
  task automatic wait_pulse(input bit abort);
    for (int i = 0; i < 400; i++) begin
      @(negedge ref_clk);
      if ((abort ? conv_abort : conv_start) === 1'b1) begin
        return;
      end
    end
    failures++;
    results();
  endtask

  // follows four scan steps and compares each lit position with row,
  // then what the lamps of every position caught
  task automatic show(input logic [33:0] row);
    logic [1:0] last;
    logic [7:0] exp;
    int i;
    for (int k = 0; k < 4; k++) begin
      last = digit_sel;
      for (i = 0; i < 40 && digit_sel === last; i++) @(negedge ref_clk);
      if (i == 40) begin
        failures++;
        results();
      end
      if (k > 0) check("scan period", 10'h010, 10'(i));
      exp = (digit_sel == 2'h3) ? 8'h00 : row[8 * digit_sel +: 8];
      check("digit order", {8'h00, last + 2'h1}, {8'h00, digit_sel});
      check("segment bus", {2'h0, exp}, {2'h0, seg_bus});
    end
    // the newest position reaches its lamps one edge later
    @(negedge ref_clk);
    for (int p = 0; p < 3; p++) begin
      check("lit digit", {2'h0, row[8 * p +: 8]}, {2'h0, lit[8 * p +: 8]});
    end
    check("dark digit", 10'h000, {2'h0, lit[31:24]});
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    check("reset segments", 10'h000, {2'h0, seg_bus});
    check("reset digit", 10'h000, {8'h00, digit_sel});
    foreach (rows[r]) begin
      @(posedge ref_clk);
      value <= rows[r][33:24];
      wait_pulse(1'b0);
      check("channel", 10'h001, {6'h00, conv_channel});
      wait_pulse(1'b0);
      show(rows[r]);
    end
    // a conversion outlasting the sample period is aborted, display kept
    @(posedge ref_clk);
    conv_len <= 16'h012c;
    value <= 10'h2a5;
    wait_pulse(1'b1);
    @(negedge ref_clk);
    check("restart", 10'h001, {9'h000, conv_start});
    show(rows[7]);
    // reset in mid-run: outputs clear at once, then a dark display scans
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    check("mid reset segments", 10'h000, {2'h0, seg_bus});
    check("mid reset digit", 10'h000, {8'h00, digit_sel});
    @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    show(34'h0_0000_0000);
    results();
  end
endmodule // testbench
